// ---- core/fprc_defines.svh ----
// Purpose: Constants for the four-bit presettable ripple counter.
// Assumes: Included by bare name from core design files.
// Notes:   Definitions only.
`ifndef FPRC_DEFINES_SVH
`define FPRC_DEFINES_SVH
// Reset values of counting stages and synchronisers
`define FPRC_Q_RST       4'h0
`define FPRC_SYNC_RST    1'b1
// Top count of each second-stage variant
`define FPRC_DIV5_TOP    3'h4
`define FPRC_DIV8_TOP    3'h7
// Top value of the combined decimal count
`define FPRC_BCD_TOP     4'h9
// Codes on the mode select pins
`define FPRC_CODE_SEP    2'h0
`define FPRC_CODE_BCD    2'h1
`define FPRC_CODE_BIQ    2'h2
`endif

// ---- core/fprc_pkg.sv ----
// Purpose: Types shared by the counter design.
// Assumes: Nothing.
// Notes:   Modes are one-hot.
package fprc_pkg;
   // Interconnection of the two counting stages
   typedef enum logic [2:0] {
      FPRC_SEPARATE                 = 3'h1,
      FPRC_CASCADE                  = 3'h2,
      FPRC_FIVE_THEN_TWO_SQUARE_MODE = 3'h4
   } fprc_mode_t;
endpackage : fprc_pkg

// ---- core/fprc_pin_sync.sv ----
// Purpose: Two-flop synchroniser with falling-edge pulse for one pin.
// Assumes: Pin is asynchronous to CLK; idles high.
// Notes:   First flop feeds only the second flop.
`timescale 1ns/10ps
`include "fprc_defines.svh"
module fprc_pin_sync (
   input  wire logic CLK,
   input  wire logic SYS_RST,
   input  wire logic PIN,
   output logic      LEVEL,
   output logic      FALL
);
   logic meta_ff;  // First synchroniser stage
   logic sync_ff;  // Second synchroniser stage
   logic prev_ff;  // Delayed copy for edge detection

   // Synchroniser chain and edge history
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         meta_ff <= `FPRC_SYNC_RST;
         sync_ff <= `FPRC_SYNC_RST;
         prev_ff <= `FPRC_SYNC_RST;
      end else begin
         meta_ff <= PIN;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign LEVEL = sync_ff;
   // High-to-low only; rising edges give nothing
   assign FALL  = prev_ff & ~sync_ff;
endmodule : fprc_pin_sync

// ---- core/fprc_top.sv ----
// Purpose: Four-bit presettable counter, decade or binary variant.
// Assumes: All pins asynchronous to CLK; pin pulses wider than 3 CLK periods.
// Notes:   Pins are synchronised; counts and loads show 3 CLK after a pin edge.
// Operation
// R1: Decade variant counts decimal zero to nine.
// R2: Decade has separate divide-by-two, divide-by-five stages.
// R3: Five-then-two arrangement gives tenth-rate square wave.
// R4: Binary variant divides by two, four, eight, sixteen.
// R5: Strobe low loads data inputs to outputs.
// R6: Clear low forces all outputs zero.
// R7: Stages advance only on falling clock edges.
// R8: Outside wiring chains first stage into second. Here MODE_SEL code 1 chains them inside the design instead.
`timescale 1ns/10ps
`include "fprc_defines.svh"
module fprc_top
   import fprc_pkg::*;
#(
   parameter bit DECADE = 1'b1    // 1: decade variant, 0: binary variant
) (
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   input  wire logic       CLOCK_ONE,           // First stage clock pin
   input  wire logic       CLOCK_TWO,           // Second stage clock pin
   input  wire logic [3:0] DATA_IN,             // Parallel preset data
   input  wire logic       STROBE_N,            // Load strobe, active low
   input  wire logic       CLEAR_N,             // Common clear, active low
   input  wire logic [1:0] MODE_SEL,            // Stage interconnection
   input  wire logic [1:0] DIV_SEL,             // Divider tap select
   output logic [3:0]      Q_OUT,               // Counter outputs
   output logic            FIRST_STAGE_OUTPUT,  // Divide-by-two stage output
   output logic            DIV_OUT              // Selected divider tap
);
   logic       c1_fall;    // Falling edge on first clock pin
   logic       c2_fall;    // Falling edge on second clock pin
   logic       strobe_n_s; // Synchronised strobe
   logic       clear_n_s;  // Synchronised clear
   logic [3:0] data_m_ff;  // Data first sync stage
   logic [3:0] data_s_ff;  // Data second sync stage
   logic [1:0] mode_m_ff;  // Mode first sync stage
   logic [1:0] mode_s_ff;  // Mode second sync stage
   logic [1:0] dsel_m_ff;  // Tap select first sync stage
   logic [1:0] dsel_s_ff;  // Tap select second sync stage
   logic       q0_ff;      // First stage bit
   logic [2:0] hi_ff;      // Second stage bits 3..1
   logic       div_ff;     // Registered tap
   logic       nxt_q0;
   logic [2:0] nxt_hi;
   logic       nxt_div;
   fprc_mode_t mode;       // Decoded interconnection
   logic       step_one;   // First stage advances this cycle
   logic       step_two;   // Second stage advances this cycle
   logic [2:0] hi_top;     // Wrap value of second stage

   // Wrapping increment of the second stage
   function automatic logic [2:0] fprc_inc(input logic [2:0] v, input logic [2:0] top);
      fprc_inc = (v >= top) ? 3'h0 : 3'(v + 3'h1);
   endfunction : fprc_inc

   fprc_pin_sync u_sync_c1 (.CLK(CLK), .SYS_RST(SYS_RST), .PIN(CLOCK_ONE),
                            .LEVEL(), .FALL(c1_fall));
   fprc_pin_sync u_sync_c2 (.CLK(CLK), .SYS_RST(SYS_RST), .PIN(CLOCK_TWO),
                            .LEVEL(), .FALL(c2_fall));
   fprc_pin_sync u_sync_st (.CLK(CLK), .SYS_RST(SYS_RST), .PIN(STROBE_N),
                            .LEVEL(strobe_n_s), .FALL());
   fprc_pin_sync u_sync_cl (.CLK(CLK), .SYS_RST(SYS_RST), .PIN(CLEAR_N),
                            .LEVEL(clear_n_s), .FALL());

   // Static pins pass two flops before use
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         data_m_ff <= 4'h0;
         data_s_ff <= 4'h0;
         mode_m_ff <= 2'h0;
         mode_s_ff <= 2'h0;
         dsel_m_ff <= 2'h0;
         dsel_s_ff <= 2'h0;
      end else begin
         data_m_ff <= DATA_IN;
         data_s_ff <= data_m_ff;
         mode_m_ff <= MODE_SEL;
         mode_s_ff <= mode_m_ff;
         dsel_m_ff <= DIV_SEL;
         dsel_s_ff <= dsel_m_ff;
      end
   end

   // Mode decode; unknown codes run stages separately
   assign mode = (mode_s_ff == `FPRC_CODE_BCD) ? FPRC_CASCADE :
                 (mode_s_ff == `FPRC_CODE_BIQ) ? FPRC_FIVE_THEN_TWO_SQUARE_MODE :
                 FPRC_SEPARATE;

   // Second stage is divide-by-five in decade, by-eight in binary
   assign hi_top = DECADE ? `FPRC_DIV5_TOP : `FPRC_DIV8_TOP; // R2 R4

   // Stage clocks: pins, or the other stage's falling output
   always_comb begin
      step_one = 1'b0;
      step_two = 1'b0;
      case (mode)
         FPRC_SEPARATE: begin
            step_one = c1_fall;  // R2 R7
            step_two = c2_fall;  // R2 R7
         end
         FPRC_CASCADE: begin
            // First stage output falling clocks the second stage
            step_one = c1_fall;           // R7 R8
            step_two = c1_fall & q0_ff;   // R1 R4 R8
         end
         FPRC_FIVE_THEN_TWO_SQUARE_MODE: begin
            // Divide-by-five wrap clocks the toggle stage
            step_two = c2_fall;                                  // R7
            step_one = DECADE & c2_fall & (hi_ff >= hi_top);     // R3
         end
         default: begin
            step_one = 1'b0;
            step_two = 1'b0;
         end
      endcase
   end

   // Next state: clear over strobe over counting
   always_comb begin
      nxt_q0 = q0_ff;
      nxt_hi = hi_ff;
      if (!clear_n_s) begin
         nxt_q0 = 1'b0;             // R6
         nxt_hi = 3'h0;             // R6
      end else if (!strobe_n_s) begin
         nxt_q0 = data_s_ff[0];     // R5
         nxt_hi = data_s_ff[3:1];   // R5
      end else begin
         if (step_one) begin
            nxt_q0 = ~q0_ff;        // R2
         end
         if (step_two) begin
            nxt_hi = fprc_inc(hi_ff, hi_top); // R1 R2 R4
         end
      end
   end

   // Divider tap: bit 0..3 gives divide by 2,4,8,16 in the binary variant
   assign nxt_div = Q_OUT[dsel_s_ff]; // R4

   // Counter and tap registers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         q0_ff  <= 1'b0;
         hi_ff  <= 3'h0;
         div_ff <= 1'b0;
      end else begin
         q0_ff  <= nxt_q0;
         hi_ff  <= nxt_hi;
         div_ff <= nxt_div;
      end
   end

   // Outputs come straight from the stage flops and the tap flop
   assign Q_OUT              = {hi_ff, q0_ff};
   assign FIRST_STAGE_OUTPUT = q0_ff;
   assign DIV_OUT            = div_ff;

   // Clear low zeroes all four bits next cycle
   a_clear_forces_zero: assert property (@(posedge CLK) disable iff (SYS_RST) // R6
      !clear_n_s |=> (Q_OUT == `FPRC_Q_RST))
      else $error("Clear did not zero outputs");

   // Strobe low copies synchronised data to the outputs
   a_strobe_loads_data: assert property (@(posedge CLK) disable iff (SYS_RST) // R5
      (clear_n_s && !strobe_n_s) |=> (Q_OUT == $past(data_s_ff)))
      else $error("Strobe did not load data");

   // Decimal count returns to zero after nine
   a_bcd_nine_wraps: assert property (@(posedge CLK) disable iff (SYS_RST) // R1
      (DECADE && mode == FPRC_CASCADE && clear_n_s && strobe_n_s && c1_fall
       && Q_OUT == `FPRC_BCD_TOP) |=> (Q_OUT == 4'h0))
      else $error("Decimal count did not wrap after nine");

   // No falling edge, no load, no clear: count holds
   a_idle_holds_count: assert property (@(posedge CLK) disable iff (SYS_RST) // R7
      (clear_n_s && strobe_n_s && !c1_fall && !c2_fall) |=> $stable(Q_OUT))
      else $error("Count moved without a falling edge");

   // Divide-by-five stage wraps from four to zero
   a_div5_stage_wrap: assert property (@(posedge CLK) disable iff (SYS_RST) // R2
      (DECADE && clear_n_s && strobe_n_s && step_two && hi_ff == `FPRC_DIV5_TOP)
      |=> (hi_ff == 3'h0))
      else $error("Divide-by-five stage did not wrap at four");

   // Divide-by-two stage toggles on every step
   a_div2_stage_toggle: assert property (@(posedge CLK) disable iff (SYS_RST) // R2
      (clear_n_s && strobe_n_s && step_one) |=> (q0_ff != $past(q0_ff)))
      else $error("Divide-by-two stage did not toggle");

   // Square output keeps its level on the step from two, inside a half period
   a_square_half_ten: assert property (@(posedge CLK) disable iff (SYS_RST) // R3
      (DECADE && mode == FPRC_FIVE_THEN_TWO_SQUARE_MODE && clear_n_s && strobe_n_s
       && c2_fall && hi_ff == 3'h2) |=> (q0_ff == $past(q0_ff)))
      else $error("Square output toggled mid half-period");

   // Tap register lags the selected bit by one cycle
   a_tap_follows_sel: assert property (@(posedge CLK) disable iff (SYS_RST) // R4
      ##1 (DIV_OUT == $past(Q_OUT[dsel_s_ff])))
      else $error("Divider tap does not follow selected bit");

   // Binary count returns to zero after fifteen
   a_bin_wraps_fifteen: assert property (@(posedge CLK) disable iff (SYS_RST) // R4
      (!DECADE && mode == FPRC_CASCADE && clear_n_s && strobe_n_s && c1_fall
       && Q_OUT == {`FPRC_DIV8_TOP, 1'b1}) |=> (Q_OUT == 4'h0))
      else $error("Binary count did not wrap after fifteen");

   // Square output flips when the divide-by-five stage wraps
   a_square_wrap_toggle: assert property (@(posedge CLK) disable iff (SYS_RST) // R3
      (DECADE && mode == FPRC_FIVE_THEN_TWO_SQUARE_MODE && clear_n_s && strobe_n_s
       && c2_fall && hi_ff == `FPRC_DIV5_TOP) |=> (q0_ff != $past(q0_ff)))
      else $error("Square output did not flip at divide-by-five wrap");

   // Second stage holds while the first stage rises
   a_cascade_carry_gate: assert property (@(posedge CLK) disable iff (SYS_RST) // R1
      (mode == FPRC_CASCADE && clear_n_s && strobe_n_s && c1_fall && !q0_ff)
      |=> (hi_ff == $past(hi_ff)))
      else $error("Second stage stepped without a first stage fall");
endmodule : fprc_top

// ---- verif/fprc_ctl_model.sv ----
// Purpose: Clock source and preset/clear control logic driving the counter pins.
// Assumes: Requests change on CLK falls and stand for at least 4 CLK periods.
// Notes:   Requests are taken on a CLK rise; pins move on the next CLK fall.
`timescale 1ns/10ps
module fprc_ctl_model (
   input  wire logic       CLK,
   input  wire logic       GO_ONE,     // Pull the first clock pin low
   input  wire logic       GO_TWO,     // Pull the second clock pin low
   input  wire logic       GO_LOAD,    // Hold the load strobe low
   input  wire logic       GO_CLEAR,   // Hold the common clear low
   input  wire logic [3:0] PRESET,     // Value for the data pins
   output logic            CLOCK_ONE,
   output logic            CLOCK_TWO,
   output logic [3:0]      DATA_IN,
   output logic            STROBE_N,
   output logic            CLEAR_N
);
   logic       one_ff;     // Taken request, first clock
   logic       two_ff;     // Taken request, second clock
   logic       load_ff;    // Taken request, strobe
   logic       clear_ff;   // Taken request, clear
   logic [3:0] preset_ff;  // Taken data value
   // Requests are taken away from the edge on which the bench moves them
   always_ff @(posedge CLK) begin
      one_ff    <= GO_ONE;
      two_ff    <= GO_TWO;
      load_ff   <= GO_LOAD;
      clear_ff  <= GO_CLEAR;
      preset_ff <= PRESET;
   end
   // Clock, strobe and clear pins idle high, data pins follow the taken preset; all move on the CLK fall; each clock pin follows its own request
   always_ff @(negedge CLK) begin
      CLOCK_ONE <= ~one_ff;
      CLOCK_TWO <= ~two_ff;
      DATA_IN   <= preset_ff;
      STROBE_N  <= ~load_ff;
      CLEAR_N   <= ~clear_ff;
   end
endmodule : fprc_ctl_model

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the decade and binary counter variants.
// Assumes: Both variants share the same pins from one control model.
// Notes:   Each scenario is a task that judges its own results.
`timescale 1ns/10ps
module testbench;
   logic       clk = 1'b0;        // 250 MHz system clock
   logic       sys_rst = 1'b1;    // Synchronous reset
   logic [1:0] mode_sel = 2'h1;   // Stage interconnection
   logic [1:0] div_sel = 2'h0;    // Divider tap
   wire        c1, c2, stb_n, clr_n, fso, div, div_b;
   wire  [3:0] din, q, q_b;
   int         err_count = 0;
   int         compares = 0;
   int         cycles = 0;
   logic       go_one = 1'b0;     // Request low on first clock pin
   logic       go_two = 1'b0;     // Request low on second clock pin
   logic       go_load = 1'b0;    // Request load strobe
   logic       go_clear = 1'b0;   // Request common clear
   logic [3:0] preset = 4'h0;     // Value offered on the data pins
   // Clock, 4 ns period
   always #2 clk = ~clk;
   fprc_ctl_model m (.CLK(clk), .GO_ONE(go_one), .GO_TWO(go_two), .GO_LOAD(go_load),
      .GO_CLEAR(go_clear), .PRESET(preset), .CLOCK_ONE(c1), .CLOCK_TWO(c2),
      .DATA_IN(din), .STROBE_N(stb_n), .CLEAR_N(clr_n));
   fprc_top #(.DECADE(1'b1)) dut (.CLK(clk), .SYS_RST(sys_rst), .CLOCK_ONE(c1),
      .CLOCK_TWO(c2), .DATA_IN(din), .STROBE_N(stb_n), .CLEAR_N(clr_n),
      .MODE_SEL(mode_sel), .DIV_SEL(div_sel), .Q_OUT(q), .FIRST_STAGE_OUTPUT(fso),
      .DIV_OUT(div));
   fprc_top #(.DECADE(1'b0)) dut_bin (.CLK(clk), .SYS_RST(sys_rst), .CLOCK_ONE(c1),
      .CLOCK_TWO(c2), .DATA_IN(din), .STROBE_N(stb_n), .CLEAR_N(clr_n),
      .MODE_SEL(mode_sel), .DIV_SEL(div_sel), .Q_OUT(q_b), .FIRST_STAGE_OUTPUT(),
      .DIV_OUT(div_b));
   // Compares one value and reports a mismatch
   task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Waits a number of CLK falling edges
   task automatic pin_hold(input int n);
      repeat (n) @(negedge clk);
   endtask : pin_hold
   // One full pulse on a stage clock; two picks the second stage clock, else the first
   task automatic pin_fall(input bit two);
      if (two) go_two = 1'b1;
      else go_one = 1'b1;
      pin_hold(4);
      go_one = 1'b0;
      go_two = 1'b0;
      pin_hold(4);
   endtask : pin_fall
   // Strobed parallel entry of a preset value
   task automatic pin_load(input logic [3:0] d);
      preset  = d;
      go_load = 1'b1;
      pin_hold(4);
      go_load = 1'b0;
      pin_hold(4);
   endtask : pin_load
   // Common clear pulse
   task automatic pin_clear();
      go_clear = 1'b1;
      pin_hold(4);
      go_clear = 1'b0;
      pin_hold(4);
   endtask : pin_clear
   // Verdict and end of run
   task automatic report_and_stop();
      if (err_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   // Cascade counts zero to nine and wraps; rising edges change nothing
   task automatic t_bcd();
      mode_sel = 2'h1;
      pin_clear();
      for (int i = 1; i <= 10; i++) begin
         pin_fall(1'b0);
         chk("bcd", 4'(i % 10), q);
         chk("first", 4'(i % 2), {3'h0, fso});
      end
   endtask : t_bcd
   // Preset, count on from it, then clear
   task automatic t_load();
      pin_load(4'h6);
      chk("load", 4'h6, q);
      chk("loadbin", 4'h6, q_b);
      pin_fall(1'b0);
      chk("after", 4'h7, q);
      pin_clear();
      chk("clear", 4'h0, q);
      chk("clrbin", 4'h0, q_b);
   endtask : t_load
   // Separate divide-by-two and divide-by-five stages
   task automatic t_sep();
      mode_sel = 2'h0;
      pin_clear();
      pin_fall(1'b0);
      chk("div2", 4'h1, q);
      for (int i = 1; i <= 5; i++) begin
         pin_fall(1'b1);
         chk("div5", 4'((i % 5) * 2 + 1), q);
      end
   endtask : t_sep
   // Five-then-two gives five low then five high per ten clocks
   task automatic t_sq();
      mode_sel = 2'h2;
      pin_clear();
      for (int i = 1; i <= 10; i++) begin
         pin_fall(1'b1);
         chk("square", {3'h0, (i >= 5 && i < 10)}, {3'h0, q[0]});
      end
   endtask : t_sq
   // Binary variant taps divide by two, four, eight, sixteen; decade taps too
   task automatic t_bin();
      logic [3:0] cnt;
      logic [3:0] cnt_d;
      mode_sel = 2'h1;
      pin_clear();
      for (int i = 1; i <= 16; i++) begin
         pin_fall(1'b0);
         cnt   = 4'(i);
         cnt_d = 4'(i % 10);
         chk("bin", cnt, q_b);
         chk("dec", cnt_d, q);
         for (int k = 0; k < 4; k++) begin
            div_sel = 2'(k);
            pin_hold(5);
            chk("tap", {3'h0, cnt[k]}, {3'h0, div_b});
            chk("tapdec", {3'h0, cnt_d[k]}, {3'h0, div});
         end
      end
   endtask : t_bin
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         report_and_stop();
      end
   end
   // Main sequence
   initial begin
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      pin_hold(2);
      t_bcd();
      t_load();
      t_sep();
      t_sq();
      t_bin();
      report_and_stop();
   end
endmodule : testbench
